//--- rtl/dsam_top.sv
// Two-channel alarm monitor with register port, status and indicator line.
// Assumes all sensor words update on one shared sample strobe.
`include "dsam_map.svh"
module dsam_top (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port.
  input wire logic [`DSAM_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Sensor words, unfiltered and filtered, indexed by source code.
  input wire logic smp_stb,
  input wire logic [16*16-1:0] raw_words,
  input wire logic [16*16-1:0] filt_words,
  // Outputs.
  output logic digital_line_one,
  output logic digital_line_two,
  output logic irq
);
  import dsam_pkg::*;
  logic rs1_q, rst_n;
  logic [15:0] mag1_q, mag2_q, smpl1_q, smpl2_q, cfg_q, diag_q, mask_q;
  logic [1:0] trig;
  logic [15:0] words [2];
  logic sel_mag1, sel_mag2, sel_s1, sel_s2, sel_cfg, sel_diag, sel_mask;
  logic [15:0] rd_mux;
  logic [1:0] rise_q, trig_d1;
  logic any_alarm, line_level;

  // Reset release through two flops.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // Address decode.
  assign sel_mag1 = reg_addr == `DSAM_OFS_MAG1;
  assign sel_mag2 = reg_addr == `DSAM_OFS_MAG2;
  assign sel_s1 = reg_addr == `DSAM_OFS_SMPL1;
  assign sel_s2 = reg_addr == `DSAM_OFS_SMPL2;
  assign sel_cfg = reg_addr == `DSAM_OFS_CTRL;
  assign sel_diag = reg_addr == `DSAM_OFS_DIAG;
  assign sel_mask = reg_addr == `DSAM_OFS_IMASK;

  // Read selection; unmapped offsets read zero.
  assign rd_mux = sel_mag1 ? mag1_q :
                  sel_mag2 ? mag2_q :
                  sel_s1 ? smpl1_q :
                  sel_s2 ? smpl2_q :
                  sel_cfg ? cfg_q :
                  sel_diag ? diag_q :
                  sel_mask ? mask_q : 16'h0000;

  // Writable registers; unused bits are held at zero.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mag1_q <= `DSAM_RST_16;
      mag2_q <= `DSAM_RST_16;
      smpl1_q <= `DSAM_RST_16;
      smpl2_q <= `DSAM_RST_16;
      cfg_q <= `DSAM_RST_16;
      mask_q <= `DSAM_RST_16;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && sel_mag1) mag1_q <= reg_wdata & `DSAM_MAG_MASK;
      if (reg_wr && sel_mag2) mag2_q <= reg_wdata & `DSAM_MAG_MASK;
      if (reg_wr && sel_s1) smpl1_q <= reg_wdata & `DSAM_SMPL_MASK;
      if (reg_wr && sel_s2) smpl2_q <= reg_wdata & `DSAM_SMPL_MASK;
      if (reg_wr && sel_cfg) cfg_q <= reg_wdata & `DSAM_CTRL_MASK;
      if (reg_wr && sel_mask) mask_q <= reg_wdata & `DSAM_DIAG_MASK;
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // Source pick per channel, filtered or raw.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [3:0] src;
    logic [15:0] word_raw, word_filt;
    assign src = (c == 0) ? cfg_q[`DSAM_CTRL_SRC1_MSB:`DSAM_CTRL_SRC1_LSB]
                          : cfg_q[`DSAM_CTRL_SRC2_MSB:`DSAM_CTRL_SRC2_LSB];
    assign word_raw = raw_words[src*16 +: 16];
    assign word_filt = filt_words[src*16 +: 16];
    assign words[c] = cfg_q[`DSAM_CTRL_FILT] ? word_filt : word_raw;

    dsam_channel #(.DEPTH(`DSAM_HIST_DEPTH)) u_ch (
      .clk(ref_clk),
      .rst_n(rst_n),
      .enable(dsam_src_t'(src) inside {DSAM_SRC_SUPPLY, DSAM_SRC_RATE_X, DSAM_SRC_RATE_Y,
              DSAM_SRC_RATE_Z, DSAM_SRC_ACC_X, DSAM_SRC_ACC_Y, DSAM_SRC_ACC_Z,
              DSAM_SRC_FLD_X, DSAM_SRC_FLD_Y, DSAM_SRC_FLD_Z, DSAM_SRC_AUX}),
      .dynamic((c == 0) ? cfg_q[`DSAM_CTRL_DYN1] : cfg_q[`DSAM_CTRL_DYN2]),
      .magnitude((c == 0) ? mag1_q : mag2_q),
      .window((c == 0) ? smpl1_q[`DSAM_SMPL_MSB:0] : smpl2_q[`DSAM_SMPL_MSB:0]),
      .smp_stb(smp_stb),
      .smp(words[c]),
      .trig(trig[c])
    );
  end

  // Indicator level and sticky status with set-over-clear.
  assign any_alarm = |trig;
  assign line_level = (cfg_q[`DSAM_CTRL_IND_EN] && any_alarm) ?
                      cfg_q[`DSAM_CTRL_IND_POL] : !cfg_q[`DSAM_CTRL_IND_POL];
  assign rise_q = trig & ~trig_d1;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_q <= `DSAM_RST_16;
      trig_d1 <= 2'b00;
      irq <= 1'b0;
      digital_line_one <= 1'b1;
      digital_line_two <= 1'b1;
    end else begin
      trig_d1 <= trig;
      diag_q[`DSAM_DIAG_ALM_LSB +: 2] <= rise_q | trig |
        (diag_q[`DSAM_DIAG_ALM_LSB +: 2] &
         ~((reg_wr && sel_diag) ? reg_wdata[`DSAM_DIAG_ALM_LSB +: 2] : 2'b00));
      irq <= |(diag_q & mask_q);
      // Unselected line stays idle high.
      digital_line_one <= cfg_q[`DSAM_CTRL_IND_SEL] ? 1'b1 : line_level;
      digital_line_two <= cfg_q[`DSAM_CTRL_IND_SEL] ? line_level : 1'b1;
    end
  end
endmodule // dsam_top

//--- rtl/dsam_map.svh
// Register offsets, field positions and reset values of the alarm monitor.
// Assumes a 16-bit register port addressed by the printed byte offsets.
// Contract
// - Window two low byte; zero or one is one
// - Two status bits report each alarm's trigger
// - Config bits 15:12 pick alarm two source
// - Config bits 11:8 pick alarm one source
// - Config bit 7 selects alarm two dynamic
// - Config bit 6 selects alarm one dynamic
// - Config bit 4 selects filtered source data
// - Config bit 2 enables hardware indicator line
// - Config bit 1 sets indicator active level
// - Config bit 0 picks line two over one
// - Static compare; threshold bit 15 sets sense
// - Dynamic: change over window exceeds threshold
// - Threshold is 14 bits, source format
`ifndef DSAM_MAP_SVH
`define DSAM_MAP_SVH
`define DSAM_ADDR_W 8
`define DSAM_OFS_MAG1 8'h44
`define DSAM_OFS_MAG2 8'h46
`define DSAM_OFS_SMPL1 8'h48
`define DSAM_OFS_SMPL2 8'h4a
`define DSAM_OFS_CTRL 8'h4c
`define DSAM_OFS_DIAG 8'h3c
`define DSAM_OFS_IMASK 8'h3e
`define DSAM_RST_16 16'h0000
`define DSAM_MAG_SENSE 15
`define DSAM_MAG_THR_MSB 13
`define DSAM_SMPL_MSB 7
`define DSAM_CTRL_SRC2_MSB 15
`define DSAM_CTRL_SRC2_LSB 12
`define DSAM_CTRL_SRC1_MSB 11
`define DSAM_CTRL_SRC1_LSB 8
`define DSAM_CTRL_DYN2 7
`define DSAM_CTRL_DYN1 6
`define DSAM_CTRL_FILT 4
`define DSAM_CTRL_IND_EN 2
`define DSAM_CTRL_IND_POL 1
`define DSAM_CTRL_IND_SEL 0
`define DSAM_DIAG_ALM_LSB 8
`define DSAM_CTRL_MASK 16'hffd7
`define DSAM_MAG_MASK 16'hbfff
`define DSAM_SMPL_MASK 16'h00ff
`define DSAM_DIAG_MASK 16'h0300
`define DSAM_HIST_DEPTH 256
`endif

//--- rtl/dsam_pkg.sv
// Types shared by the alarm monitor files.
// Assumes the map header is included wherever offsets are needed.
package dsam_pkg;
  // Source selector codes; 1000 and 1101..1111 pick nothing.
  typedef enum logic [3:0] {
    DSAM_SRC_OFF = 4'h0,
    DSAM_SRC_SUPPLY = 4'h1,
    DSAM_SRC_RATE_X = 4'h2,
    DSAM_SRC_RATE_Y = 4'h3,
    DSAM_SRC_RATE_Z = 4'h4,
    DSAM_SRC_ACC_X = 4'h5,
    DSAM_SRC_ACC_Y = 4'h6,
    DSAM_SRC_ACC_Z = 4'h7,
    DSAM_SRC_FLD_X = 4'h9,
    DSAM_SRC_FLD_Y = 4'ha,
    DSAM_SRC_FLD_Z = 4'hb,
    DSAM_SRC_AUX = 4'hc
  } dsam_src_t;
  // Channel sequencing states.
  typedef enum logic [1:0] {DSAM_IDLE, DSAM_FILL, DSAM_RUN} dsam_state_t;
endpackage

//--- rtl/dsam_channel.sv
// One alarm channel: static or rate-of-change compare of a 16-bit word to a 14-bit threshold.
// Assumes samples arrive as single-cycle strobes with a sign-extended word.
`include "dsam_map.svh"
module dsam_channel #(
  parameter int DEPTH = 256
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Configuration.
  input wire logic enable,
  input wire logic dynamic,
  input wire logic [15:0] magnitude,
  input wire logic [7:0] window,
  // Sample stream.
  input wire logic smp_stb,
  input wire logic signed [15:0] smp,
  // Result.
  output logic trig
);
  import dsam_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic signed [15:0] hist [DEPTH];
  logic [AW-1:0] wr_q;
  logic [8:0] fill_q;
  dsam_state_t state_q;
  logic signed [13:0] thr;
  logic signed [16:0] delta;
  logic [16:0] abs_delta;
  logic [7:0] win_eff;
  logic [AW-1:0] rd_ptr;
  logic above, below, stat_hit, dyn_hit, ready;

  // Window of zero counts as one sample.
  assign win_eff = (window == 8'h00) ? 8'h01 : window;
  assign rd_ptr = wr_q - AW'(win_eff);
  assign thr = magnitude[`DSAM_MAG_THR_MSB:0];
  assign above = 16'(signed'(thr)) < smp;
  assign below = smp < 16'(signed'(thr));
  assign stat_hit = magnitude[`DSAM_MAG_SENSE] ? above : below;
  assign delta = 17'(smp) - 17'(hist[rd_ptr]);
  assign abs_delta = delta[16] ? 17'(-delta) : 17'(delta);
  assign ready = (state_q == DSAM_RUN) && (fill_q >= 9'(win_eff));
  assign dyn_hit = ready && (abs_delta > 17'(magnitude[`DSAM_MAG_THR_MSB:0]));

  // Sample history ring; fill_q counts fill level and saturates at 511.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      fill_q <= '0;
      state_q <= DSAM_IDLE;
      trig <= 1'b0;
    end else begin
      case (state_q)
        DSAM_IDLE: begin
          fill_q <= '0;
          trig <= 1'b0;
          if (enable) state_q <= DSAM_RUN;
        end
        default: begin
          if (!enable) state_q <= DSAM_IDLE;
          if (smp_stb) begin
            wr_q <= wr_q + 1'b1;
            if (fill_q != 9'h1ff) fill_q <= fill_q + 1'b1;
            trig <= dynamic ? dyn_hit : stat_hit;
          end
        end
      endcase
    end
  end

  // History storage has no reset.
  always_ff @(posedge clk) begin
    if (smp_stb) hist[wr_q] <= smp;
  end
endmodule // dsam_channel

//--- sim/dsam_top_checker.sv
// Checker for the alarm monitor's register port, interrupt and indicator lines.
// Assumes it is bound to the top module and sees only its ports.
`include "dsam_map.svh"
module dsam_top_checker (
  // Watched ports.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`DSAM_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic digital_line_one,
  input wire logic digital_line_two,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cfg_q;
  logic [15:0] mask_q;
  logic [1:0] age_q;
  logic [1:0] age_d;
  logic cfg_wr;
  logic act_line;
  logic idle_line;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Age saturates at three so lines are judged only once settled.
  assign cfg_wr = reg_wr && reg_addr == `DSAM_OFS_CTRL;
  assign age_d = cfg_wr ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
  assign act_line = cfg_q[0] ? digital_line_two : digital_line_one;
  assign idle_line = cfg_q[0] ? digital_line_one : digital_line_two;
  // Shadow copies of configuration and interrupt mask.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= 16'h0;
      mask_q <= 16'h0;
      age_q <= 2'h0;
    end else begin
      if (cfg_wr) cfg_q <= reg_wdata & `DSAM_CTRL_MASK;
      if (reg_wr && reg_addr == `DSAM_OFS_IMASK) mask_q <= reg_wdata & 16'h0300;
      age_q <= age_d;
    end
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data not zero outside a read");
  cfg_read_a: assert property (reg_rd && reg_addr == `DSAM_OFS_CTRL |=> reg_rdata == cfg_q)
    else $error("configuration read mismatch");
  window_read_a: assert property (reg_wr && reg_addr == `DSAM_OFS_SMPL2 ##1 !reg_wr
    ##1 reg_rd && reg_addr == `DSAM_OFS_SMPL2 |=> reg_rdata == ($past(reg_wdata, 3) & 16'h00ff))
    else $error("window two read mismatch");
  mag_spare_a: assert property (reg_rd && reg_addr inside {8'h44, 8'h46} |=> !reg_rdata[14])
    else $error("threshold spare bit reads one");
  spare_line_a: assert property (age_q == 2'h3 |-> idle_line)
    else $error("unselected line not high");
  idle_level_a: assert property (age_q == 2'h3 && !cfg_q[2] |-> act_line == !cfg_q[1])
    else $error("disabled indicator not at inactive level");
  irq_masked_a: assert property (mask_q == 16'h0 && $past(mask_q) == 16'h0 |-> !irq)
    else $error("interrupt high with all masked");
  irq_cause_a: assert property (irq |-> $past(mask_q) != 16'h0)
    else $error("interrupt high without mask enable");
endmodule // dsam_top_checker

bind dsam_top dsam_top_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .digital_line_one(digital_line_one), .digital_line_two(digital_line_two), .irq(irq));

//--- sim/dsam_host.sv
// Host-side model that watches the indicator lines as firmware would.
// Assumes the host knows the line select and polarity it programmed.
module dsam_host (
  // Indicator lines.
  input wire logic digital_line_one,
  input wire logic digital_line_two,
  // Programmed indicator setup.
  input wire logic sel,
  input wire logic pol,
  // Alarm as seen by the host.
  output logic active
);
  timeunit 1ns;
  timeprecision 1ps;
  // The chosen line at its active level means an alarm.
  assign active = (sel ? digital_line_two : digital_line_one) == pol;
endmodule // dsam_host

//--- sim/dsam_top_tb_top.sv
// Self-checking bench for the alarm monitor: registers, alarms and indicator.
// Assumes design, checker and host model are compiled before it.
module dsam_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic smp_stb = 1'b0;
  logic [255:0] raw_words = '0;
  logic [255:0] filt_words = '0;
  logic [15:0] reg_rdata;
  logic line_one, line_two, irq, active, t;
  logic h_sel = 1'b0;
  logic h_pol = 1'b0;
  logic [15:0] cfg;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] ofs [6] = '{8'h44, 8'h46, 8'h48, 8'h4a, 8'h4c, 8'h3e};
  logic [15:0] msk [6] = '{16'hbfff, 16'hbfff, 16'h00ff, 16'h00ff, 16'hffd7, 16'h0300};
  // Clock of 25 ns period.
  always #12.5 ref_clk = ~ref_clk;
  dsam_top dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_stb(smp_stb),
    .raw_words(raw_words), .filt_words(filt_words), .digital_line_one(line_one),
    .digital_line_two(line_two), .irq(irq));
  dsam_host host (.digital_line_one(line_one), .digital_line_two(line_two), .sel(h_sel),
    .pol(h_pol), .active(active));
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask
  // One sample on word k, then wait until lines and interrupt have settled.
  task automatic smp(int k, logic [15:0] v, logic f);
    logic [255:0] w;
    w = '0;
    w[k*16+:16] = v;
    @(posedge ref_clk);
    raw_words <= f ? '0 : w;
    filt_words <= f ? w : '0;
    smp_stb <= 1'b1;
    @(posedge ref_clk);
    smp_stb <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Cut a hung run short well beyond the expected length.
  initial begin
    #125000;
    n_fail++;
    complete_run();
  end
  // Main sequence: registers, source codes 0 to 12, boundary compare, rate alarm.
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h3c, 16'h0);
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], 16'h0);
      wr(ofs[i], 16'hffff);
      rd(ofs[i], msk[i]);
    end
    wr(8'h50, 16'hffff);
    rd(8'h50, 16'h0);
    wr(8'h44, 16'h8064);
    wr(8'h46, 16'h8064);
    for (int c = 0; c < 13; c++) begin
      cfg = {c[3:0], c[3:0], 3'h0, c[0], 1'b0, c[2:0]};
      t = (c != 0 && c != 8);
      h_sel <= c[0];
      h_pol <= c[1];
      wr(8'h4c, cfg);
      smp(c, 16'd200, c[0]);
      chk("irq", {15'h0, t}, {15'h0, irq});
      rd(8'h3c, {6'h0, t, t, 8'h0});
      chk("alarm_seen", {15'h0, c[2] && t}, {15'h0, active});
      chk("spare_line", 16'h1, {15'h0, c[0] ? line_one : line_two});
      smp(c, 16'h0, c[0]);
      chk("alarm_idle", 16'h0, {15'h0, active});
      wr(8'h3c, 16'h0300);
      rd(8'h3c, 16'h0);
    end
    wr(8'h44, 16'h3ffb);
    wr(8'h4c, 16'h0700);
    smp(7, 16'hfffb, 1'b0);
    rd(8'h3c, 16'h0);
    smp(7, 16'hfffa, 1'b0);
    rd(8'h3c, 16'h0100);
    smp(7, 16'h0, 1'b0);
    wr(8'h3c, 16'h0100);
    wr(8'h3e, 16'h0);
    wr(8'h44, 16'h0032);
    wr(8'h46, 16'h0032);
    wr(8'h48, 16'h0001);
    wr(8'h4a, 16'h0000);
    wr(8'h4c, 16'h77c0);
    h_sel <= 1'b0;
    h_pol <= 1'b0;
    smp(7, 16'h0, 1'b0);
    smp(7, 16'd50, 1'b0);
    rd(8'h3c, 16'h0);
    smp(7, 16'd101, 1'b0);
    rd(8'h3c, 16'h0300);
    chk("irq", 16'h0, {15'h0, irq});
    chk("alarm_seen", 16'h0, {15'h0, active});
    complete_run();
  end
endmodule // dsam_top_tb_top
